// ### hw/dbcm_regs.svh
`ifndef DBCM_REGS_SVH
`define DBCM_REGS_SVH

// Register locations on the external interface.
`define DBCM_REG_CMD 12'h000
`define DBCM_REG_DPTR 12'h001

// Command/status register fields.
`define DBCM_CS_START 0
`define DBCM_CS_MULTI 1
`define DBCM_CS_DONE 2
`define DBCM_CS_ERR 3

// Descriptor word offsets and stride.
`define DBCM_DW_CTRL 12'h000
`define DBCM_DW_CW1 12'h001
`define DBCM_DW_CW2 12'h002
`define DBCM_DW_SW1 12'h003
`define DBCM_DW_SW2 12'h004
`define DBCM_DW_DATA 12'h005
`define DBCM_DW_STAT 12'h006
`define DBCM_DW_STRIDE 12'h008

// Descriptor word 0 fields and operation codes.
`define DBCM_D0_OP_HI 3
`define DBCM_D0_RTRT 4
`define DBCM_D0_BUSB 5
`define DBCM_OP_ONE 4'h1
`define DBCM_OP_NEXT 4'h2

// Descriptor word 6 fields.
`define DBCM_ST_CNT_HI 7
`define DBCM_ST_DONE 8
`define DBCM_ST_ERR 9
`define DBCM_ST_SW1 10
`define DBCM_ST_SW2 11

// Command and status word fields.
`define DBCM_CW_TR 10
`define DBCM_CW_SA_HI 9
`define DBCM_CW_SA_LO 5
`define DBCM_CW_MDATA 4
`define DBCM_CW_WC_HI 4
`define DBCM_SA_MODE0 5'h00
`define DBCM_SA_MODE31 5'h1F
`define DBCM_SW_MERR 10

// Word counts.
`define DBCM_WC_FULL 6'h20
`define DBCM_MODE_ONE 6'h01

// Timing in nanoseconds and derived cycle counts, rounded up.
`define DBCM_CLK_NS 25
`define DBCM_RESP_TO_NS 14000
`define DBCM_RTRT_TO_NS 57000
`define DBCM_RESP_TO_CYC ((`DBCM_RESP_TO_NS + `DBCM_CLK_NS - 1) / `DBCM_CLK_NS)
`define DBCM_RTRT_TO_CYC ((`DBCM_RTRT_TO_NS + `DBCM_CLK_NS - 1) / `DBCM_CLK_NS)

// Transmit buffer shape.
`define DBCM_FIFO_DEPTH 8
`define DBCM_FIFO_WIDTH 18

`endif

// ### hw/dbcm_pkg.sv
package dbcm_pkg;

	// Sequencer states.
	typedef enum logic [3:0] {
		S_IDLE,
		S_FETCH,
		S_CW1,
		S_CW2,
		S_DRD,
		S_DPUSH,
		S_WSW1,
		S_RXD,
		S_WSW2,
		S_STAT,
		S_NEXT
	} dbcm_state_e;

	typedef logic [15:0] dbcm_word_t;

endpackage

// ### hw/dbcm_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module dbcm_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Full and empty follow the occupancy count.
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// Storage is written only on an accepted push.
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers wrap at the depth, which is a power of two.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= AW'(wr_ptr + 1'b1);
			if (pop)
				rd_ptr <= AW'(rd_ptr + 1'b1);
			if (push && !pop)
				count <= (AW+1)'(count + 1'b1);
			else if (pop && !push)
				count <= (AW+1)'(count - 1'b1);
		end
	end
endmodule // dbcm_fifo

`default_nettype wire

// ### hw/dbcm_timer.sv
`timescale 1ns/100ps
`default_nettype none

module dbcm_timer #(
	parameter int W = 12
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clr,
	input wire logic run,
	input wire logic [W-1:0] limit,
	output logic expired
);
	logic [W-1:0] cnt;

	// Expiry holds once the limit is reached until cleared.
	assign expired = (cnt >= limit);

	// Counts enabled cycles; a clear restarts from zero.
	always_ff @(posedge mclk)
	begin
		if (rst || clr)
			cnt <= '0;
		else if (run && !expired)
			cnt <= W'(cnt + 1'b1);
	end
endmodule // dbcm_timer

`default_nettype wire

// ### hw/dbcm_top.sv
// Function
// - Descriptors live in a 4K-word memory the host can access.
// - Host register writes launch messages; host builds lists first.
// - Writing one to command/status bit 0 starts descriptor processing.
// - Command/status bit 1 picks single command or multiple commands.
// - Word 0 opcode 0x0 stops; 0x1 does the message then stops.
// - Opcode 0x2 does the message then continues eight words further.
// - Word 0 bit 4 marks RT-to-RT: two commands, two statuses.
// - Word 0 bit 5 selects bus: zero bus A, one bus B.
// - Word 1 is normal or receive command; word 2 transmit command.
// - Word 3 takes first status; word 4 takes receiver's status.
// - Word 5 points to data buffer, or holds mode-code data.
// - Word 6 gets received count, done bit 8, error bit 9.
`timescale 1ns/100ps
`default_nettype none
`include "dbcm_regs.svh"

module dbcm_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ext_req,
	input wire logic ext_we,
	input wire logic [11:0] ext_addr,
	input wire logic [15:0] ext_wdata,
	output logic [15:0] ext_rdata,
	output logic ext_ack,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [15:0] tx_word,
	output logic tx_cmd,
	output logic tx_bus_b,
	input wire logic rx_valid,
	input wire logic [15:0] rx_word,
	input wire logic rx_status,
	input wire logic rx_bus_b,
	output logic bc_busy
);
	logic [15:0] mem [0:4095];
	dbcm_pkg::dbcm_state_e state;
	dbcm_pkg::dbcm_state_e next_state;
	dbcm_pkg::dbcm_word_t mem_q;
	dbcm_pkg::dbcm_word_t d_ctrl;
	dbcm_pkg::dbcm_word_t d_cw1;
	dbcm_pkg::dbcm_word_t d_cw2;
	dbcm_pkg::dbcm_word_t d_data;
	logic [11:0] dptr;
	logic [11:0] desc;
	logic cs_multi;
	logic cs_done;
	logic cs_err;
	logic [2:0] fc;
	logic [5:0] idx;
	logic got1;
	logic got2;
	logic merr;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [17:0] fifo_out_data;
	logic tmo;

	// Host access decode.
	wire host_wr = ext_req && ext_we;
	wire hit_cmd = (ext_addr == `DBCM_REG_CMD);
	wire hit_dptr = (ext_addr == `DBCM_REG_DPTR);
	wire hit_mem = !hit_cmd && !hit_dptr;
	wire start_req = host_wr && hit_cmd && ext_wdata[`DBCM_CS_START]
		&& (state == dbcm_pkg::S_IDLE);
	wire busy = (state != dbcm_pkg::S_IDLE);
	wire [15:0] cs_word = {12'h000, cs_err, cs_done, cs_multi, busy};
	wire [15:0] host_rd = hit_cmd ? cs_word :
		hit_dptr ? {4'h0, dptr} : mem[ext_addr];

	wire [3:0] opcode = d_ctrl[`DBCM_D0_OP_HI:0];
	wire op_run = (opcode == `DBCM_OP_ONE) || (opcode == `DBCM_OP_NEXT);
	wire rtrt = d_ctrl[`DBCM_D0_RTRT];
	wire bus_b = d_ctrl[`DBCM_D0_BUSB];

	// Message shape from the first command word.
	wire [4:0] sa = d_cw1[`DBCM_CW_SA_HI:`DBCM_CW_SA_LO];
	wire is_mode = (sa == `DBCM_SA_MODE0) || (sa == `DBCM_SA_MODE31);
	wire [4:0] wc = d_cw1[`DBCM_CW_WC_HI:0];
	wire [5:0] n_norm = (wc == 5'h00) ? `DBCM_WC_FULL : {1'b0, wc};
	wire [5:0] n_words = is_mode ?
		(d_cw1[`DBCM_CW_MDATA] ? `DBCM_MODE_ONE : 6'h00) : n_norm;
	wire tr = d_cw1[`DBCM_CW_TR];
	wire bc_tx = !rtrt && !tr && (n_words != 6'h00);
	wire rx_dmsg = rtrt || (tr && (n_words != 6'h00));
	wire last = (6'(idx + 6'h01) == n_words);

	// Received word qualification on the selected bus.
	wire rx_hit = rx_valid && (rx_bus_b == bus_b);
	wire sw_take = rx_hit && rx_status
		&& ((state == dbcm_pkg::S_WSW1) || (state == dbcm_pkg::S_WSW2));
	wire dw_take = rx_hit && !rx_status && (state == dbcm_pkg::S_RXD);
	wire stat_wr = (state == dbcm_pkg::S_STAT);

	wire [11:0] buf_addr = 12'(d_data[11:0] + {6'h00, idx});
	wire [11:0] rx_dst = is_mode ? 12'(desc + `DBCM_DW_DATA) : buf_addr;
	wire [11:0] sw_dst = (state == dbcm_pkg::S_WSW2) ?
		12'(desc + `DBCM_DW_SW2) : 12'(desc + `DBCM_DW_SW1);
	wire [7:0] rx_count = rx_dmsg ? {2'b00, idx} : 8'h00;
	wire [15:0] stat_word;
	assign stat_word[`DBCM_ST_CNT_HI:0] = rx_count;
	assign stat_word[`DBCM_ST_DONE] = 1'b1;
	assign stat_word[`DBCM_ST_ERR] = merr;
	assign stat_word[`DBCM_ST_SW1] = got1;
	assign stat_word[`DBCM_ST_SW2] = got2;
	assign stat_word[15:12] = 4'h0;

	// Sequencer write port into the memory.
	wire fsm_we = sw_take || dw_take || stat_wr;
	wire [11:0] fsm_waddr = stat_wr ? 12'(desc + `DBCM_DW_STAT) :
		sw_take ? sw_dst : rx_dst;
	wire [15:0] fsm_wdata = stat_wr ? stat_word : rx_word;

	// Sequencer read address: descriptor fields, then data buffer.
	wire [11:0] fetch_off = (fc == 3'h0) ? `DBCM_DW_CTRL :
		(fc == 3'h1) ? `DBCM_DW_CW1 :
		(fc == 3'h2) ? `DBCM_DW_CW2 : `DBCM_DW_DATA;
	wire [11:0] fsm_raddr = (state == dbcm_pkg::S_FETCH) ?
		12'(desc + fetch_off) : buf_addr;

	wire push_valid = (state == dbcm_pkg::S_CW1)
		|| (state == dbcm_pkg::S_CW2) || (state == dbcm_pkg::S_DPUSH);
	wire [15:0] push_word = (state == dbcm_pkg::S_CW1) ? d_cw1 :
		(state == dbcm_pkg::S_CW2) ? d_cw2 :
		(is_mode ? d_data : mem_q);
	wire push_cmd = (state != dbcm_pkg::S_DPUSH);
	wire [17:0] push_data = {bus_b, push_cmd, push_word};
	wire push_fire = push_valid && fifo_in_ready;

	// Output stage reloads when empty or when the link takes the word.
	wire out_ld = fifo_out_valid && (!tx_valid || tx_ready);
	wire tx_idle = !fifo_out_valid && !tx_valid;

	// Response timer runs only after the last word has left.
	wire waiting = (state == dbcm_pkg::S_WSW1)
		|| (state == dbcm_pkg::S_RXD) || (state == dbcm_pkg::S_WSW2);
	wire tmr_clr = !waiting || sw_take || dw_take;
	wire [11:0] tmr_limit = (rtrt && (state != dbcm_pkg::S_WSW2)) ?
		12'(`DBCM_RTRT_TO_CYC) : 12'(`DBCM_RESP_TO_CYC);
	wire chain = cs_multi && (opcode == `DBCM_OP_NEXT);

	dbcm_fifo #(
		.WIDTH(`DBCM_FIFO_WIDTH),
		.DEPTH(`DBCM_FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(push_valid),
		.in_ready(fifo_in_ready),
		.in_data(push_data),
		.out_valid(fifo_out_valid),
		.out_ready(out_ld),
		.out_data(fifo_out_data)
	);

	dbcm_timer #(
		.W(12)
	) u_timer (
		.mclk(mclk),
		.rst(rst),
		.clr(tmr_clr),
		.run(tx_idle),
		.limit(tmr_limit),
		.expired(tmo)
	);

	// Next state of the descriptor sequencer.
	always_comb
	begin
		next_state = state;
		case (state)
			dbcm_pkg::S_IDLE:
				if (start_req)
					next_state = dbcm_pkg::S_FETCH;
			dbcm_pkg::S_FETCH:
				if (fc == 3'h4)
					next_state = op_run ? dbcm_pkg::S_CW1 : dbcm_pkg::S_IDLE;
			dbcm_pkg::S_CW1:
				if (fifo_in_ready)
				begin
					if (rtrt)
						next_state = dbcm_pkg::S_CW2;
					else if (bc_tx)
						next_state = is_mode ? dbcm_pkg::S_DPUSH : dbcm_pkg::S_DRD;
					else
						next_state = dbcm_pkg::S_WSW1;
				end
			dbcm_pkg::S_CW2:
				if (fifo_in_ready)
					next_state = dbcm_pkg::S_WSW1;
			dbcm_pkg::S_DRD:
				next_state = dbcm_pkg::S_DPUSH;
			dbcm_pkg::S_DPUSH:
				if (fifo_in_ready)
					next_state = last ? dbcm_pkg::S_WSW1 : dbcm_pkg::S_DRD;
			dbcm_pkg::S_WSW1:
				if (sw_take)
					next_state = rx_dmsg ? dbcm_pkg::S_RXD : dbcm_pkg::S_STAT;
				else if (tmo)
					next_state = dbcm_pkg::S_STAT;
			dbcm_pkg::S_RXD:
				if (dw_take && last)
					next_state = rtrt ? dbcm_pkg::S_WSW2 : dbcm_pkg::S_STAT;
				else if (tmo)
					next_state = dbcm_pkg::S_STAT;
			dbcm_pkg::S_WSW2:
				if (sw_take || tmo)
					next_state = dbcm_pkg::S_STAT;
			dbcm_pkg::S_STAT:
				next_state = dbcm_pkg::S_NEXT;
			dbcm_pkg::S_NEXT:
				next_state = chain ? dbcm_pkg::S_FETCH : dbcm_pkg::S_IDLE;
			default:
				next_state = dbcm_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (fsm_we)
			mem[fsm_waddr] <= fsm_wdata;
		else if (host_wr && hit_mem)
			mem[ext_addr] <= ext_wdata;
		mem_q <= mem[fsm_raddr];
	end

	// Host answer one cycle after each request.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			ext_ack <= 1'b0;
			ext_rdata <= 16'h0000;
		end
		else
		begin
			ext_ack <= ext_req;
			ext_rdata <= (ext_req && !ext_we) ? host_rd : 16'h0000;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dptr <= 12'h000;
			cs_multi <= 1'b0;
		end
		else
		begin
			if (host_wr && hit_dptr)
				dptr <= ext_wdata[11:0];
			if (host_wr && hit_cmd)
				cs_multi <= ext_wdata[`DBCM_CS_MULTI];
		end
	end

	// Run flags: start clears both; completion sets done, a status write with an error sets error.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			cs_done <= 1'b0;
			cs_err <= 1'b0;
		end
		else if (start_req)
		begin
			cs_done <= 1'b0;
			cs_err <= 1'b0;
		end
		else
		begin
			if (busy && (next_state == dbcm_pkg::S_IDLE))
				cs_done <= 1'b1;
			if (stat_wr && merr)
				cs_err <= 1'b1;
		end
	end

	// Sequencer state and descriptor walk.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state <= dbcm_pkg::S_IDLE;
			desc <= 12'h000;
			fc <= 3'h0;
		end
		else
		begin
			state <= next_state;
			fc <= (state == dbcm_pkg::S_FETCH) ? 3'(fc + 3'h1) : 3'h0;
			if (start_req)
				desc <= dptr;
			else if ((state == dbcm_pkg::S_NEXT) && chain)
				desc <= 12'(desc + `DBCM_DW_STRIDE);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			d_ctrl <= 16'h0000;
			d_cw1 <= 16'h0000;
			d_cw2 <= 16'h0000;
			d_data <= 16'h0000;
		end
		else if (state == dbcm_pkg::S_FETCH)
		begin
			if (fc == 3'h1)
				d_ctrl <= mem_q;
			if (fc == 3'h2)
				d_cw1 <= mem_q;
			if (fc == 3'h3)
				d_cw2 <= mem_q;
			if (fc == 3'h4)
				d_data <= mem_q;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst || (state == dbcm_pkg::S_FETCH))
		begin
			idx <= 6'h00;
			merr <= 1'b0;
		end
		else
		begin
			if ((state == dbcm_pkg::S_DPUSH && push_fire) || dw_take)
				idx <= 6'(idx + 6'h01);
			if ((waiting && tmo && !sw_take && !dw_take)
				|| (sw_take && rx_word[`DBCM_SW_MERR]))
				merr <= 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst || (state == dbcm_pkg::S_FETCH))
		begin
			got1 <= 1'b0;
			got2 <= 1'b0;
		end
		else if (sw_take)
		begin
			if (state == dbcm_pkg::S_WSW1)
				got1 <= 1'b1;
			else
				got2 <= 1'b1;
		end
	end

	// link output stage carries the bus select
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			tx_valid <= 1'b0;
			tx_word <= 16'h0000;
			tx_cmd <= 1'b0;
			tx_bus_b <= 1'b0;
			bc_busy <= 1'b0;
		end
		else
		begin
			if (out_ld)
			begin
				tx_valid <= 1'b1;
				{tx_bus_b, tx_cmd, tx_word} <= fifo_out_data;
			end
			else if (tx_ready)
				tx_valid <= 1'b0;
			bc_busy <= (next_state != dbcm_pkg::S_IDLE);
		end
	end
endmodule // dbcm_top

`default_nettype wire

// ### test/dbcm_rt_model.sv
`timescale 1ns/100ps
`default_nettype none

// Remote terminals that answer every command on the bus it came on.
module dbcm_rt_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic mute,
	input wire logic tx_valid,
	input wire logic [15:0] tx_word,
	input wire logic tx_cmd,
	input wire logic tx_bus_b,
	output logic tx_ready,
	output logic rx_valid,
	output logic [15:0] rx_word,
	output logic rx_status,
	output logic rx_bus_b,
	output logic last_bus_b
);
	logic [16:0] q[$];
	logic [16:0] v;
	logic [15:0] sw;
	logic [1:0] cyc = 2'h0;
	int rc;
	int gap;
	bit owe;
	initial {rx_valid, rx_word, rx_status, rx_bus_b, last_bus_b} = 19'h00000;
	// One stalled cycle in four keeps the buffer busy.
	assign tx_ready = (cyc != 2'h0);
	// Data words a command carries; mode codes carry at most one.
	function automatic int nw(input logic [15:0] c);
		if (c[9:5] == 5'h00 || c[9:5] == 5'h1F)
			return c[4] ? 1 : 0;
		return (c[4:0] == 5'h00) ? 32 : int'(c[4:0]);
	endfunction
	// Owed status goes out once the receiver has its words.
	task automatic dec();
		rc--;
		if (owe && rc == 0)
		begin
			owe = 0;
			q.push_back({1'b1, sw});
			gap = 8;
		end
	endtask
	// Replies are spaced out; idle lines show the inverse of the last value.
	always @(posedge mclk)
	begin
		cyc <= cyc + 2'h1;
		rx_valid <= 1'b0;
		rx_word <= ~rx_word;
		rx_status <= ~rx_status;
		if (rst)
		begin
			q.delete();
			owe = 0;
			gap = 0;
		end
		else if (tx_valid && tx_ready)
		begin
			last_bus_b <= tx_bus_b;
			rx_bus_b <= tx_bus_b;
			if (tx_cmd && tx_word[10])
			begin
				q.push_back({1'b1, tx_word[15:11], 11'h000});
				for (int i = 0; i < nw(tx_word); i++)
					q.push_back({1'b0, 16'h1000 + 16'(i)});
				gap = 8;
			end
			else if (tx_cmd)
			begin
				// One extra count lets a receive with no data answer at once.
				rc = nw(tx_word) + 1;
				owe = 1;
				sw = {tx_word[15:11], 11'h000};
				dec();
			end
			else
				dec();
		end
		else if (q.size() != 0 && !mute)
		begin
			if (gap != 0)
				gap--;
			else
			begin
				v = q.pop_front();
				{rx_status, rx_word} <= v;
				rx_valid <= 1'b1;
				gap = 3;
				if (!v[16])
					dec();
			end
		end
	end
endmodule // dbcm_rt_model

`default_nettype wire

// ### test/dbcm_checker.sv
`timescale 1ns/100ps
`default_nettype none

// Port-level checks of the bus controller.
module dbcm_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ext_req,
	input wire logic ext_we,
	input wire logic [11:0] ext_addr,
	input wire logic [15:0] ext_wdata,
	input wire logic [15:0] ext_rdata,
	input wire logic ext_ack,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [15:0] tx_word,
	input wire logic tx_cmd,
	input wire logic tx_bus_b,
	input wire logic rx_valid,
	input wire logic [15:0] rx_word,
	input wire logic rx_status,
	input wire logic rx_bus_b,
	input wire logic bc_busy
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	AST_ACK: assert property (ext_req |=> ext_ack)
		else $error("no ack after request");
	AST_NOACK: assert property (!ext_req |=> !ext_ack)
		else $error("ack without request");
	AST_RDZ: assert property (!ext_ack |-> ext_rdata == 16'h0000)
		else $error("read data outside ack");
	AST_TXHOLD: assert property (tx_valid && !tx_ready |=> tx_valid &&
		$stable(tx_word) && $stable(tx_cmd) && $stable(tx_bus_b))
		else $error("offered word changed");
	AST_START: assert property (ext_req && ext_we &&
		ext_addr == 12'h000 && ext_wdata[0] && !bc_busy |-> ##[1:3] bc_busy)
		else $error("start ignored");
	AST_TXBUSY: assert property (tx_valid |-> bc_busy)
		else $error("word offered while idle");
	AST_RSTOUT: assert property ($fell(rst) |->
		!bc_busy && !tx_valid && !ext_ack)
		else $error("outputs active after reset");
	AST_CSRSV: assert property (ext_ack && !$past(ext_we) &&
		$past(ext_addr) == 12'h000 |-> ext_rdata[15:4] == 12'h000)
		else $error("reserved status bits set");
	CV_RUN: cover property ($rose(bc_busy));
	CV_STALL: cover property (tx_valid && !tx_ready);
	CV_RX: cover property (rx_valid && rx_status && bc_busy);
endmodule // dbcm_checker

`default_nettype wire

// ### test/dbcm_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module dbcm_top_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ext_req = 1'b0;
	logic ext_we = 1'b0;
	logic [11:0] ext_addr = 12'h000;
	logic [15:0] ext_wdata = 16'h0000;
	logic [15:0] ext_rdata;
	logic [15:0] q;
	logic ext_ack, tx_valid, tx_ready, tx_cmd, tx_bus_b, bc_busy, mute;
	logic rx_valid, rx_status, rx_bus_b, last_bus_b;
	logic [15:0] tx_word, rx_word;
	int error_cnt = 0;
	int n_checks = 0;
	logic [15:0] last_data = 16'h0000;
	dbcm_top u_dut (.mclk(mclk), .rst(rst), .ext_req(ext_req), .ext_we(ext_we),
		.ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
		.ext_ack(ext_ack), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_word(tx_word), .tx_cmd(tx_cmd), .tx_bus_b(tx_bus_b),
		.rx_valid(rx_valid), .rx_word(rx_word), .rx_status(rx_status),
		.rx_bus_b(rx_bus_b), .bc_busy(bc_busy));
	dbcm_rt_model u_rt (.mclk(mclk), .rst(rst), .mute(mute), .tx_valid(tx_valid),
		.tx_word(tx_word), .tx_cmd(tx_cmd), .tx_bus_b(tx_bus_b),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_word(rx_word),
		.rx_status(rx_status), .rx_bus_b(rx_bus_b), .last_bus_b(last_bus_b));
	// Clock at 40 MHz.
	initial forever #12.5 mclk = ~mclk;
	// Keeps the last data word the link took.
	always @(posedge mclk)
		if (tx_valid && tx_ready && !tx_cmd)
			last_data <= tx_word;
	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One host access: a single request cycle, answer in the next.
	task acc(input logic we, input logic [11:0] a, input logic [15:0] d);
		@(posedge mclk) #1;
		{ext_req, ext_we, ext_addr, ext_wdata} = {1'b1, we, a, d};
		@(posedge mclk) #1;
		ext_req = 1'b0;
		chk({15'h0000, ext_ack}, 16'h0001);
		q = ext_rdata;
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		acc(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000);
		chk(q, e);
	endtask
	task desc(input logic [11:0] b, input logic [15:0] w0, c1, c2, dp);
		wr(b, w0);
		wr(b + 12'h001, c1);
		wr(b + 12'h002, c2);
		wr(b + 12'h003, 16'h0000);
		wr(b + 12'h004, 16'h0000);
		wr(b + 12'h005, dp);
		wr(b + 12'h006, 16'h0000);
	endtask
	task run(input logic [11:0] p, input logic [15:0] cs);
		wr(12'h001, {4'h0, p});
		wr(12'h000, cs);
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 4000 && bc_busy !== 1'b0; i++)
			@(posedge mclk);
		#1;
		chk({15'h0000, bc_busy}, 16'h0000);
	endtask
	initial
	begin
		#(25 * 30000);
		error_cnt++;
		tally_and_finish();
	end
	initial
	begin
		mute = 1'b0;
		repeat (20) @(posedge mclk);
		#1 rst = 1'b0;
		rd(12'h000, 16'h0000);
		rd(12'h001, 16'h0000);
		wr(12'hFFF, 16'hA5C3);
		rd(12'hFFF, 16'hA5C3);
		desc(12'h100, 16'h0002, 16'h0824, 16'h0000, 16'h0200);
		desc(12'h108, 16'h0021, 16'h0C63, 16'h0000, 16'h0300);
		desc(12'h110, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		for (int i = 0; i < 4; i++)
			wr(12'h200 + 12'(i), 16'h0001 + 16'(i));
		run(12'h100, 16'h0003);
		rd(12'h000, 16'h0006);
		rd(12'h103, 16'h0800);
		rd(12'h106, 16'h0500);
		rd(12'h10B, 16'h0800);
		rd(12'h10E, 16'h0503);
		rd(12'h116, 16'h0000);
		for (int i = 0; i < 3; i++)
			rd(12'h300 + 12'(i), 16'h1000 + 16'(i));
		chk({15'h0000, last_bus_b}, 16'h0001);
		chk(last_data, 16'h0004);
		wr(12'h106, 16'h0000);
		wr(12'h10E, 16'h0000);
		run(12'h100, 16'h0001);
		rd(12'h106, 16'h0500);
		rd(12'h10E, 16'h0000);
		chk({15'h0000, last_bus_b}, 16'h0000);
		desc(12'h120, 16'h0011, 16'h1042, 16'h0C42, 16'h0340);
		run(12'h120, 16'h0001);
		rd(12'h123, 16'h0800);
		rd(12'h124, 16'h1000);
		rd(12'h126, 16'h0D02);
		rd(12'h340, 16'h1000);
		rd(12'h341, 16'h1001);
		desc(12'h140, 16'h0001, 16'h0C10, 16'h0000, 16'h0000);
		run(12'h140, 16'h0001);
		rd(12'h145, 16'h1000);
		rd(12'h146, 16'h0501);
		desc(12'h130, 16'h0001, 16'h0C63, 16'h0000, 16'h0380);
		mute = 1'b1;
		run(12'h130, 16'h0001);
		rd(12'h136, 16'h0300);
		rd(12'h000, 16'h000C);
		tally_and_finish();
	end
endmodule // dbcm_top_tb

bind dbcm_top dbcm_checker u_chk (.mclk(mclk), .rst(rst), .ext_req(ext_req),
	.ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
	.ext_rdata(ext_rdata), .ext_ack(ext_ack), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_word(tx_word), .tx_cmd(tx_cmd),
	.tx_bus_b(tx_bus_b), .rx_valid(rx_valid), .rx_word(rx_word),
	.rx_status(rx_status), .rx_bus_b(rx_bus_b), .bc_busy(bc_busy));

`default_nettype wire
